// [logic/phy_setup_consts.vh]
// Purpose: shared offsets, field positions, reset values and timing for the phy setup block
// Assumes: 100 MHz system clock
// Notes:   definitions only
`ifndef PHY_SETUP_CONSTS_VH
`define PHY_SETUP_CONSTS_VH

// register word indices on the plain register port
`define ADDR_WIDTH            3
`define ADDR_PHY_CONTROL      3'h0
`define ADDR_IDENT_WORD1      3'h1
`define ADDR_IDENT_WORD2      3'h2
`define ADDR_MGMT_ADDRESS     3'h3
`define ADDR_PHY_STATUS       3'h4

// control, status and management address register fields
`define CTRL_RESERVED_ONE_BIT 15
`define CTRL_RESET_N_BIT      14
`define CTRL_CLKSEL_BIT       13
`define CTRL_MODE_MSB         2
`define CTRL_MODE_LSB         0
`define STATUS_POWERUP_BIT    15
`define MGMT_ADDRESS_MSB      4

// reset values: power-on keeps the phy powered down, standby loads the fixed image
`define CTRL_POR_VALUE        16'hc006
`define CTRL_STANDBY_VALUE    16'hc000
`define WORD_CLEAR_VALUE      16'h0000

// link mode codes
`define MODE_10_HALF          3'h0
`define MODE_10_FULL          3'h1
`define MODE_100_HALF         3'h2
`define MODE_100_FULL         3'h3
`define MODE_AN_100_HALF      3'h4
`define MODE_RESERVED         3'h5
`define MODE_POWER_DOWN       3'h6
`define MODE_AN_ALL           3'h7

// timing
`define CLOCK_FREQ_MHZ        100
`define POWERUP_RESET_TIME_US 21000
`define POWERUP_RESET_CYCLES  (`POWERUP_RESET_TIME_US * `CLOCK_FREQ_MHZ)

`endif

// [logic/powerup_reset_timer.v]
// Purpose: synchronise the analog supply detect pin and time the power-up reset window
// Assumes: i_supply_good is asynchronous to i_clock
// Notes:   the window restarts on every detected power-up
`timescale 1ns/1ps
`default_nettype none

module powerup_reset_timer
#(
  parameter integer HOLD_CYCLES = 2100000,
  parameter integer COUNT_WIDTH = 22
)
(
  // clock and reset
  input  wire i_clock,
  input  wire i_reset,
  // supply detect pin
  input  wire i_supply_good,
  // status
  output reg  o_active
);

  reg                   sync1;
  reg                   sync2;
  reg                   sync3;
  reg                   supply_level;
  reg [COUNT_WIDTH-1:0] remaining;

  localparam integer           LAST_INT   = HOLD_CYCLES - 1;
  localparam [COUNT_WIDTH-1:0] LAST_COUNT = LAST_INT[COUNT_WIDTH-1:0];

  // three-stage synchroniser; sync1 feeds sync2 only
  always @(posedge i_clock)
  begin
    sync1 <= i_supply_good;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // a new level counts only once stages two and three agree, filtering a one-sample glitch
  always @(posedge i_clock)
  begin
    if (i_reset)
      supply_level <= 1'b0;
    else if (sync2 == sync3)
      supply_level <= sync3;
  end

  // the bit is one from power-on and again on each rising supply, for exactly the hold time
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_active  <= 1'b1;
      remaining <= LAST_COUNT;
    end
    else if ((sync2 == sync3) && sync3 && !supply_level)
    begin
      o_active  <= 1'b1;
      remaining <= LAST_COUNT;
    end
    else if (o_active)
    begin
      if (remaining == {COUNT_WIDTH{1'b0}})
        o_active <= 1'b0;
      else
        remaining <= remaining - {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// [logic/phy_setup_register_interface.v]
// Purpose: register bank that configures and monitors the on-chip ethernet phy
// Assumes: one 100 MHz clock, synchronous active-high power-on reset, standby level
//          from logic on the same clock
// Notes:   configuration reaches the phy only at the release of its module reset
//
// Contract
// - written control fields reach the phy only through a module reset.
// - entering standby loads the control register with c000.
// - top control bit always reads one; software writes one there.
// - module reset bit defaults one; zero holds phy reset, one releases.
// - clock select defaults zero internal clock; one selects external phy clock.
// - mode codes 000 to 011 fix speed and duplex, auto-negotiation off.
// - mode 100 advertises 100 half only; 111 advertises everything.
// - mode 110 is default power-down; software never programs 101.
// - 100 half duplex senses carrier on transmit and receive; full on receive.
// - identifier word one register feeds phy register 2 at module reset.
// - identifier word two register feeds phy register 3 at module reset.
// - identifier and address registers clear to zero on standby.
// - address bits 4..0 hold management address; bits 15..5 read zero.
// - status bit 15 rises on supply power-up, stays 21 ms, clears.
// - status register is 16-bit read-only; bits 14..0 read zero.
// - power-on reset returns every register to its initial value.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "phy_setup_consts.vh"

module phy_setup_register_interface
#(
  parameter integer POWERUP_RESET_CYCLES = `POWERUP_RESET_CYCLES,
  parameter integer POWERUP_COUNT_WIDTH  = 22
)
(
  // clock and power-on reset
  input  wire                   i_clock,
  input  wire                   i_reset,
  // device standby level
  input  wire                   i_standby,
  // analog supply detect pin
  input  wire                   i_supply_good,
  // register port
  input  wire [`ADDR_WIDTH-1:0] i_address,
  input  wire [15:0]            i_write_data,
  input  wire                   i_write_strobe,
  input  wire                   i_read_strobe,
  output reg  [15:0]            o_read_data,
  // phy module control
  output wire                   o_module_reset_n,
  output reg                    o_clock_select_external,
  // sampled startup settings
  output reg  [2:0]             o_startup_link_mode,
  output reg  [15:0]            o_ident_word1_value,
  output reg  [15:0]            o_ident_word2_value,
  output reg  [4:0]             o_mgmt_address_value,
  // decoded startup mode
  output reg                    o_autoneg_enable,
  output reg                    o_speed_100,
  output reg                    o_full_duplex,
  output reg                    o_advertise_all,
  output reg                    o_power_down,
  output reg                    o_carrier_on_transmit,
  // phy status
  output wire                   o_powerup_reset_active
);

  //////////////////////////////////////////////////////////////////////////////////////////////

  // software-visible storage, and the previous module reset level
  reg        module_reset_n;
  reg        clock_select;
  reg [2:0]  link_mode;
  reg [15:0] ident_word1;
  reg [15:0] ident_word2;
  reg [4:0]  mgmt_address;
  reg        module_reset_n_prev;

  // access decode
  wire write_control;
  wire write_ident1;
  wire write_ident2;
  wire write_address;
  wire release_edge;

  // decoded form of the link mode held in the register
  reg next_autoneg;
  reg next_speed_100;
  reg next_full_duplex;
  reg next_advertise_all;
  reg next_power_down;
  reg next_carrier_on_tx;

  // read assembly
  reg  [15:0] next_read_data;
  wire [15:0] control_image;
  wire [15:0] status_image;
  wire        powerup_active;

  // fixed images held as sized constants, so that single fields can be picked out of them
  localparam [15:0] CONTROL_POR     = `CTRL_POR_VALUE;
  localparam [15:0] CONTROL_STANDBY = `CTRL_STANDBY_VALUE;
  localparam [15:0] WORD_CLEAR      = `WORD_CLEAR_VALUE;

  //////////////////////////////////////////////////////////////////////////////////////////////

  // write strobes per register; standby takes priority so these are gated there
  assign write_control = i_write_strobe && !i_standby && (i_address == `ADDR_PHY_CONTROL);
  assign write_ident1  = i_write_strobe && !i_standby && (i_address == `ADDR_IDENT_WORD1);
  assign write_ident2  = i_write_strobe && !i_standby && (i_address == `ADDR_IDENT_WORD2);
  assign write_address = i_write_strobe && !i_standby && (i_address == `ADDR_MGMT_ADDRESS);

  //////////////////////////////////////////////////////////////////////////////////////////////

  // control register; the reserved top bit is not stored, it is forced in the read image
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      module_reset_n <= CONTROL_POR[`CTRL_RESET_N_BIT];
      clock_select   <= CONTROL_POR[`CTRL_CLKSEL_BIT];
      link_mode      <= CONTROL_POR[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    end
    else if (i_standby)
    begin
      module_reset_n <= CONTROL_STANDBY[`CTRL_RESET_N_BIT];
      clock_select   <= CONTROL_STANDBY[`CTRL_CLKSEL_BIT];
      link_mode      <= CONTROL_STANDBY[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    end
    else if (write_control)
    begin
      module_reset_n <= i_write_data[`CTRL_RESET_N_BIT];
      clock_select   <= i_write_data[`CTRL_CLKSEL_BIT];
      link_mode      <= i_write_data[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    end
  end

  // identifier words; full 16-bit read/write
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      ident_word1 <= `WORD_CLEAR_VALUE;
      ident_word2 <= `WORD_CLEAR_VALUE;
    end
    else if (i_standby)
    begin
      ident_word1 <= `WORD_CLEAR_VALUE;
      ident_word2 <= `WORD_CLEAR_VALUE;
    end
    else
    begin
      if (write_ident1)
        ident_word1 <= i_write_data;
      if (write_ident2)
        ident_word2 <= i_write_data;
    end
  end

  // management address; only the low five bits exist, the rest are dropped on write
  always @(posedge i_clock)
  begin
    if (i_reset)
      mgmt_address <= WORD_CLEAR[`MGMT_ADDRESS_MSB:0];
    else if (i_standby)
      mgmt_address <= WORD_CLEAR[`MGMT_ADDRESS_MSB:0];
    else if (write_address)
      mgmt_address <= i_write_data[`MGMT_ADDRESS_MSB:0];
  end

  //////////////////////////////////////////////////////////////////////////////////////////////

  // the module reset goes straight to the phy; it is the one field that is not deferred
  assign o_module_reset_n = module_reset_n;

  // remember the previous reset level to find the release
  always @(posedge i_clock)
  begin
    if (i_reset)
      module_reset_n_prev <= CONTROL_POR[`CTRL_RESET_N_BIT];
    else
      module_reset_n_prev <= module_reset_n;
  end

  assign release_edge = module_reset_n && !module_reset_n_prev;

  //////////////////////////////////////////////////////////////////////////////////////////////

  // decode of the register's mode code; reserved 101 is treated as power-down so a
  // stray write cannot bring up a link in an undefined configuration
  always @*
  begin
    next_autoneg       = 1'b0;
    next_speed_100     = 1'b0;
    next_full_duplex   = 1'b0;
    next_advertise_all = 1'b0;
    next_power_down    = 1'b0;
    next_carrier_on_tx = 1'b0;
    case (link_mode)
      `MODE_10_HALF:
      begin
        next_carrier_on_tx = 1'b1;
      end
      `MODE_10_FULL:
      begin
        next_full_duplex = 1'b1;
      end
      `MODE_100_HALF:
      begin
        next_speed_100     = 1'b1;
        next_carrier_on_tx = 1'b1;
      end
      `MODE_100_FULL:
      begin
        next_speed_100   = 1'b1;
        next_full_duplex = 1'b1;
      end
      `MODE_AN_100_HALF:
      begin
        next_autoneg       = 1'b1;
        next_speed_100     = 1'b1;
        next_carrier_on_tx = 1'b1;
      end
      `MODE_AN_ALL:
      begin
        next_autoneg       = 1'b1;
        next_advertise_all = 1'b1;
        next_speed_100     = 1'b1;
        next_full_duplex   = 1'b1;
      end
      `MODE_POWER_DOWN:
      begin
        next_power_down = 1'b1;
      end
      default:
      begin
        next_power_down = 1'b1;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////////

  // startup settings seen by the phy; refreshed only when its reset is released, so a
  // write during normal running changes the register but not the phy
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_clock_select_external <= CONTROL_POR[`CTRL_CLKSEL_BIT];
      o_startup_link_mode     <= CONTROL_POR[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      o_ident_word1_value     <= `WORD_CLEAR_VALUE;
      o_ident_word2_value     <= `WORD_CLEAR_VALUE;
      o_mgmt_address_value    <= WORD_CLEAR[`MGMT_ADDRESS_MSB:0];
      o_autoneg_enable        <= 1'b0;
      o_speed_100             <= 1'b0;
      o_full_duplex           <= 1'b0;
      o_advertise_all         <= 1'b0;
      o_power_down            <= 1'b1;
      o_carrier_on_transmit   <= 1'b0;
    end
    else if (release_edge)
    begin
      o_clock_select_external <= clock_select;
      o_startup_link_mode     <= link_mode;
      o_ident_word1_value     <= ident_word1;
      o_ident_word2_value     <= ident_word2;
      o_mgmt_address_value    <= mgmt_address;
      o_autoneg_enable        <= next_autoneg;
      o_speed_100             <= next_speed_100;
      o_full_duplex           <= next_full_duplex;
      o_advertise_all         <= next_advertise_all;
      o_power_down            <= next_power_down;
      o_carrier_on_transmit   <= next_carrier_on_tx;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////

  // power-up reset window of the analog supplies
  powerup_reset_timer
  #(
    .HOLD_CYCLES (POWERUP_RESET_CYCLES),
    .COUNT_WIDTH (POWERUP_COUNT_WIDTH)
  )
  u_powerup_reset_timer
  (
    .i_clock       (i_clock),
    .i_reset       (i_reset),
    .i_supply_good (i_supply_good),
    .o_active      (powerup_active)
  );

  // software polls this bit low before setting up the phy
  assign o_powerup_reset_active = powerup_active;

  //////////////////////////////////////////////////////////////////////////////////////////////

  // read images; unused bits are constant zero, the reserved control bit constant one
  assign control_image = {1'b1,
                          module_reset_n,
                          clock_select,
                          10'h000,
                          link_mode};

  assign status_image = {powerup_active, 15'h0000};

  // read multiplexer; unmapped indices read zero
  always @*
  begin
    next_read_data = 16'h0000;
    case (i_address)
      `ADDR_PHY_CONTROL:
        next_read_data = control_image;
      `ADDR_IDENT_WORD1:
        next_read_data = ident_word1;
      `ADDR_IDENT_WORD2:
        next_read_data = ident_word2;
      `ADDR_MGMT_ADDRESS:
        next_read_data = {11'h000, mgmt_address};
      `ADDR_PHY_STATUS:
        next_read_data = status_image;
      default:
        next_read_data = 16'h0000;
    endcase
  end

  // read data stands for one cycle after the strobe, zero otherwise
  always @(posedge i_clock)
  begin
    if (i_reset)
      o_read_data <= 16'h0000;
    else if (i_read_strobe)
      o_read_data <= next_read_data;
    else
      o_read_data <= 16'h0000;
  end

endmodule

`default_nettype wire

// [tb/phy_setup_register_interface_properties.sv]
// Purpose: port-level checks for the phy setup register bank
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by bind after the module
`timescale 1ns/1ps
`default_nettype none
`include "phy_setup_consts.vh"

module phy_setup_checks
#(
  parameter integer POWERUP_RESET_CYCLES = 50,
  parameter integer POWERUP_COUNT_WIDTH  = 22
)
(
  // clock and reset
  input wire                   i_clock,
  input wire                   i_reset,
  // requests
  input wire                   i_standby,
  input wire [`ADDR_WIDTH-1:0] i_address,
  input wire [15:0]            i_write_data,
  input wire                   i_write_strobe,
  input wire                   i_read_strobe,
  // answers
  input wire [15:0]            o_read_data,
  input wire                   o_module_reset_n,
  input wire [2:0]             o_startup_link_mode,
  input wire [15:0]            o_ident_word1_value,
  input wire [4:0]             o_mgmt_address_value,
  input wire                   o_autoneg_enable,
  input wire                   o_speed_100,
  input wire                   o_full_duplex,
  input wire                   o_power_down,
  input wire                   o_carrier_on_transmit,
  input wire                   o_powerup_reset_active
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  ////////////////////////////////////////////////////////////////////////////
  // register read-back shape
  property p_ctrl_top;
    i_read_strobe && i_address == `ADDR_PHY_CONTROL |=>
      o_read_data[15] && o_read_data[12:3] == 10'h000;
  endproperty
  a_ctrl_top: assert property (p_ctrl_top) else $error("control read shape wrong");
  property p_status_read;
    i_read_strobe && i_address == `ADDR_PHY_STATUS |=>
      o_read_data == {$past(o_powerup_reset_active), 15'h0000};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
  property p_addr_high;
    i_read_strobe && i_address == `ADDR_MGMT_ADDRESS |=> o_read_data[15:5] == 11'h000;
  endproperty
  a_addr_high: assert property (p_addr_high) else $error("address high bits set");

  ////////////////////////////////////////////////////////////////////////////
  // module reset and sampled settings; decode lands with the sampled mode
  property p_reset_bit;
    i_write_strobe && i_address == `ADDR_PHY_CONTROL && !i_standby |=>
      o_module_reset_n == $past(i_write_data[14]);
  endproperty
  a_reset_bit: assert property (p_reset_bit) else $error("module reset not following");
  property p_standby;
    i_standby |=> o_module_reset_n;
  endproperty
  a_standby: assert property (p_standby) else $error("standby kept phy in reset");
  property p_hold;
    o_module_reset_n && $past(o_module_reset_n) && $past(o_module_reset_n, 2) |->
      $stable(o_startup_link_mode) && $stable(o_ident_word1_value) &&
      $stable(o_mgmt_address_value);
  endproperty
  a_hold: assert property (p_hold) else $error("settings moved without release");
  property p_fixed;
    !o_startup_link_mode[2] |-> !o_autoneg_enable && !o_power_down &&
      o_speed_100 == o_startup_link_mode[1] && o_full_duplex == o_startup_link_mode[0];
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed mode decode wrong");
  property p_an;
    o_startup_link_mode == `MODE_AN_100_HALF |-> o_autoneg_enable && o_speed_100 &&
      !o_full_duplex;
  endproperty
  a_an: assert property (p_an) else $error("autoneg decode wrong");
  property p_pd;
    o_startup_link_mode == `MODE_POWER_DOWN |-> o_power_down && !o_autoneg_enable;
  endproperty
  a_pd: assert property (p_pd) else $error("power down decode wrong");
  property p_crs;
    o_startup_link_mode == `MODE_100_HALF || o_startup_link_mode == `MODE_100_FULL |->
      o_carrier_on_transmit == !o_startup_link_mode[0];
  endproperty
  a_crs: assert property (p_crs) else $error("carrier sense decode wrong");
  property p_window;
    $rose(o_powerup_reset_active) |=> o_powerup_reset_active [*8];
  endproperty
  a_window: assert property (p_window) else $error("power-up window too short");
endmodule

bind phy_setup_register_interface phy_setup_checks
#(
  .POWERUP_RESET_CYCLES(POWERUP_RESET_CYCLES),
  .POWERUP_COUNT_WIDTH (POWERUP_COUNT_WIDTH)
)
u_checks
(
  .i_clock, .i_reset, .i_standby, .i_address, .i_write_data, .i_write_strobe,
  .i_read_strobe, .o_read_data, .o_module_reset_n, .o_startup_link_mode,
  .o_ident_word1_value, .o_mgmt_address_value, .o_autoneg_enable, .o_speed_100,
  .o_full_duplex, .o_power_down, .o_carrier_on_transmit, .o_powerup_reset_active
);
`default_nettype wire

// [tb/supply_detect_model.sv]
// Purpose: analog supply seen by the phy setup block
// Assumes: bench asks for supply on or off
// Notes:   detect pin lags the request while the supply settles
`timescale 1ns/1ps
`default_nettype none

module supply_detect_model
#(
  parameter integer RAMP_CYCLES = 4
)
(
  // clock
  input  wire logic i_clock,
  // supply request
  input  wire logic i_supply_on,
  // detect pin
  output var  logic o_supply_good
);
  int ramp = 0;

  // detect only after the ramp, so a short on-glitch of the request never shows; an off-glitch drops detect
  always @(posedge i_clock)
  begin
    ramp <= i_supply_on ? ((ramp < RAMP_CYCLES) ? ramp + 1 : ramp) : 0;
    o_supply_good <= i_supply_on && (ramp == RAMP_CYCLES);
  end
endmodule
`default_nettype wire

// [tb/phy_setup_register_interface_test.sv]
// Purpose: self-checking bench for the phy setup register bank
// Assumes: 100 MHz clock, shortened power-up window
// Notes:   phy reset hold kept full length; the long release wait is skipped
`timescale 1ns/1ps
`default_nettype none
`include "phy_setup_consts.vh"

module phy_setup_register_interface_test;
  localparam integer PWR  = 50;
  localparam integer HOLD = 10001; // just over 100 us, costs most of the run
  logic                   i_clock        = 1'b0;
  logic                   i_reset        = 1'b1;
  logic                   i_standby      = 1'b0;
  logic                   supply_on      = 1'b0;
  logic [`ADDR_WIDTH-1:0] i_address      = '0;
  logic [15:0]            i_write_data   = 16'h0000;
  logic                   i_write_strobe = 1'b0;
  logic                   i_read_strobe  = 1'b0;
  logic [15:0]            rv;
  int                     fail_count = 0;
  int                     samples_checked = 0;
  int                     n;
  int                     m;
  int                     prev = 6;
  wire                    i_supply_good;
  wire [15:0]             o_read_data;
  wire                    o_module_reset_n;
  wire                    o_clock_select_external;
  wire [2:0]              o_startup_link_mode;
  wire [15:0]             o_ident_word1_value;
  wire [15:0]             o_ident_word2_value;
  wire [4:0]              o_mgmt_address_value;
  wire                    o_autoneg_enable;
  wire                    o_speed_100;
  wire                    o_full_duplex;
  wire                    o_advertise_all;
  wire                    o_power_down;
  wire                    o_carrier_on_transmit;
  wire                    o_powerup_reset_active;

  initial forever #5 i_clock = ~i_clock;

  supply_detect_model u_supply (.i_clock, .i_supply_on(supply_on), .o_supply_good(i_supply_good));

  phy_setup_register_interface #(.POWERUP_RESET_CYCLES(PWR)) DUT
  (
    .i_clock, .i_reset, .i_standby, .i_supply_good, .i_address, .i_write_data,
    .i_write_strobe, .i_read_strobe, .o_read_data, .o_module_reset_n,
    .o_clock_select_external, .o_startup_link_mode, .o_ident_word1_value,
    .o_ident_word2_value, .o_mgmt_address_value, .o_autoneg_enable, .o_speed_100,
    .o_full_duplex, .o_advertise_all, .o_power_down, .o_carrier_on_transmit,
    .o_powerup_reset_active
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port tasks: strobe for one cycle, write data with it, read data in the next only
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_address <= a;
    i_write_data <= d;
    i_write_strobe <= 1'b1;
    @(posedge i_clock);
    i_write_strobe <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge i_clock);
    i_address <= a;
    i_read_strobe <= 1'b1;
    @(posedge i_clock);
    i_read_strobe <= 1'b0;
    #1 v = o_read_data;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // expected {autoneg, speed_100, full, advertise_all, power_down, carrier_on_tx}
  function automatic logic [5:0] dec(input int c);
    case (c)
      0: dec = 6'b000001;
      1: dec = 6'b001000;
      2: dec = 6'b010001;
      3: dec = 6'b011000;
      4: dec = 6'b110001;
      6: dec = 6'b000010;
      default: dec = 6'b111100;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(`ADDR_PHY_CONTROL, rv); cmp(rv, `CTRL_POR_VALUE);
    rd(`ADDR_IDENT_WORD1, rv); cmp(rv, 16'h0000);
    rd(3'h5, rv); cmp(rv, 16'h0000);
    rd(`ADDR_PHY_STATUS, rv); cmp(rv, 16'h8000);
    for (n = 0; n < 200 && rv[15] !== 1'b0; n++) rd(`ADDR_PHY_STATUS, rv);
    cmp(rv, 16'h0000);
    if (n == 200) end_of_test();
    wr(`ADDR_IDENT_WORD1, 16'h1234);
    wr(`ADDR_IDENT_WORD2, 16'habcd);
    wr(`ADDR_MGMT_ADDRESS, 16'hffff);
    wr(`ADDR_PHY_STATUS, 16'h7fff);
    rd(`ADDR_MGMT_ADDRESS, rv); cmp(rv, 16'h001f);
    rd(`ADDR_IDENT_WORD2, rv); cmp(rv, 16'habcd);
    rd(`ADDR_PHY_STATUS, rv); cmp(rv, 16'h0000);
    cmp(o_ident_word1_value, 16'h0000);
    // every allowed mode through a full reset and release, clock select toggling
    for (m = 0; m < 8; m++)
    begin
      if (m == 5) continue;
      wr(`ADDR_PHY_CONTROL, {2'b10, m[0], 10'h000, m[2:0]});
      #1 cmp({15'h0000, o_module_reset_n}, 16'h0000);
      cmp({13'h0000, o_startup_link_mode}, 16'(prev));
      repeat (HOLD) @(posedge i_clock);
      wr(`ADDR_PHY_CONTROL, {2'b11, m[0], 10'h000, m[2:0]});
      // no phy is modelled behind the block, so the settle wait shrinks to one cycle
      @(posedge i_clock);
      #1 cmp({15'h0000, o_module_reset_n}, 16'h0001);
      cmp({13'h0000, o_startup_link_mode}, 16'(m));
      cmp({10'h000, o_autoneg_enable, o_speed_100, o_full_duplex, o_advertise_all,
           o_power_down, o_carrier_on_transmit}, {10'h000, dec(m)});
      cmp({15'h0000, o_clock_select_external}, 16'(m % 2));
      cmp(o_ident_word1_value, 16'h1234);
      cmp(o_ident_word2_value, 16'habcd);
      cmp({11'h000, o_mgmt_address_value}, 16'h001f);
      prev = m;
    end
    // standby loads fixed images and ignores writes
    @(posedge i_clock);
    i_standby <= 1'b1;
    wr(`ADDR_IDENT_WORD1, 16'h5555);
    rd(`ADDR_PHY_CONTROL, rv); cmp(rv, `CTRL_STANDBY_VALUE);
    rd(`ADDR_IDENT_WORD1, rv); cmp(rv, 16'h0000);
    rd(`ADDR_MGMT_ADDRESS, rv); cmp(rv, 16'h0000);
    i_standby <= 1'b0;
    // supply power-up opens the status window again
    supply_on <= 1'b1;
    for (n = 0; n < 20 && o_powerup_reset_active !== 1'b1; n++) #10;
    for (n = 0; n < 200 && o_powerup_reset_active === 1'b1; n++) #10;
    cmp(16'(n), 16'(PWR));
    // second power-on reset in mid-run
    wr(`ADDR_IDENT_WORD2, 16'h0f0f);
    rd(`ADDR_IDENT_WORD2, rv); cmp(rv, 16'h0f0f);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(`ADDR_PHY_CONTROL, rv); cmp(rv, `CTRL_POR_VALUE);
    rd(`ADDR_IDENT_WORD2, rv); cmp(rv, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
